// *** design/anvp_map.vh ***
// timing counts and pin field positions for the memory port host controller
// assumes a 100 MHz system clock; counts are derived from ns figures
`ifndef ANVP_MAP_VH
`define ANVP_MAP_VH
`define ANVP_CLK_NS 10
`define ANVP_ADDR_W 17
`define ANVP_DATA_W 16
`define ANVP_COL_W 2
`define ANVP_ROW_LSB 2
`define ANVP_ROW_MSB 16
// access time, longest settle before data is sampled (least time, rounded up)
`define ANVP_ACCESS_NS 60
`define ANVP_ACCESS_CYC ((`ANVP_ACCESS_NS + `ANVP_CLK_NS - 1) / `ANVP_CLK_NS)
// page (column) access time
`define ANVP_PAGE_NS 25
`define ANVP_PAGE_CYC ((`ANVP_PAGE_NS + `ANVP_CLK_NS - 1) / `ANVP_CLK_NS)
// random_read_cycle_time
`define ANVP_RC_NS 115
`define ANVP_RC_CYC ((`ANVP_RC_NS + `ANVP_CLK_NS - 1) / `ANVP_CLK_NS)
// min_precharge_time
`define ANVP_PC_NS 60
`define ANVP_PC_CYC ((`ANVP_PC_NS + `ANVP_CLK_NS - 1) / `ANVP_CLK_NS)
// write strobe low width
`define ANVP_WP_NS 40
`define ANVP_WP_CYC ((`ANVP_WP_NS + `ANVP_CLK_NS - 1) / `ANVP_CLK_NS)
`endif

// *** design/anvp_sync3.v ***
// three-stage synchroniser bus for data pins coming back from the memory
// assumes a single system clock; second and third stages feed the agree test
`timescale 1ns/1ps
`default_nettype none
module anvp_sync3 #(
  parameter W = 16
) (
  input wire clk_i,         // system clock
  input wire rst_i,         // async reset, high
  input wire [W-1:0] d_i,   // asynchronous input
  output wire [W-1:0] q_o,  // agreed value
  output wire stable_o      // stages two and three agree
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  // ************************************************
  // sync chain; s1 is read by s2 only
  // ************************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign q_o = s3;
  assign stable_o = (s2 == s3);
endmodule // anvp_sync3
`default_nettype wire

// *** design/anvp_host.v ***
// host controller driving the asynchronous paged nonvolatile memory port
// assumes the pins go straight to the memory; data pins resolved by the bench
`timescale 1ns/1ps
`default_nettype none
`include "anvp_map.vh"
module anvp_host #(
  parameter AW = `ANVP_ADDR_W,
  parameter DW = `ANVP_DATA_W
) (
  input wire CLK_SYS_I,             // 100 MHz system clock
  input wire RST_I,                 // async reset, high
  input wire REQ_VALID_I,           // user request present
  input wire REQ_WRITE_I,           // 1 write, 0 read
  input wire [AW-1:0] REQ_ADDR_I,   // word address
  input wire [DW-1:0] REQ_WDATA_I,  // write word
  input wire [1:0] REQ_BE_I,        // byte enables, bit1 upper
  input wire REQ_LAST_I,            // end of burst: release select
  output reg REQ_READY_O,           // request taken this cycle
  output reg RSP_VALID_O,           // read word valid, one cycle
  output reg [DW-1:0] RSP_RDATA_O,  // read word
  output reg [AW-1:0] WORD_ADDR_O,  // word_addr pins
  output reg CHIP_SEL_N_O,          // chip select, active low
  output reg WRITE_STB_N_O,         // write strobe, active low
  output reg OUT_EN_N_O,            // output enable, active low
  output reg UPPER_BYTE_SEL_N_O,    // upper_byte_sel_n
  output reg LOWER_BYTE_SEL_N_O,    // lower_byte_sel_n
  input wire [DW-1:0] DATA_BUS_I,   // data_bus pin level
  output reg [DW-1:0] DATA_BUS_O,   // data_bus drive value
  output reg DATA_BUS_OE_N_O        // low while host drives data_bus
);
  // one-hot state codes
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_PRE = 6'h02;
  localparam [5:0] S_ACC = 6'h04;
  localparam [5:0] S_WLOW = 6'h08;
  localparam [5:0] S_WHIGH = 6'h10;
  localparam [5:0] S_OPEN = 6'h20;
  // timing counts in system clocks, rounded up from the ns figures
  localparam [7:0] ACC_CYC = `ANVP_ACCESS_CYC;
  localparam [7:0] PAGE_CYC = `ANVP_PAGE_CYC;
  localparam [7:0] RC_CYC = `ANVP_RC_CYC;
  localparam [7:0] PC_CYC = `ANVP_PC_CYC;
  localparam [7:0] WP_CYC = `ANVP_WP_CYC;
  // state register, one bit per phase of an access
  reg [5:0] state;
  // cnt paces the phase in hand: access wait, strobe width, hold, pre-charge
  reg [7:0] cnt;
  // rc_cnt runs from each row opening, so a new row waits out the cycle time
  reg [7:0] rc_cnt;
  // agreed data pin levels and the per-lane agree flags
  wire [DW-1:0] rd_sync;
  wire [1:0] lane_stable;
  wire [1:0] lane_off;
  wire rd_stable;
  genvar g;
  // upper address bits identify the row
  // column bits 1:0 are left out so page accesses stay in the row
  function same_row;
    input [AW-1:0] a;
    input [AW-1:0] b;
    begin
      same_row = (a[`ANVP_ROW_MSB:`ANVP_ROW_LSB] == b[`ANVP_ROW_MSB:`ANVP_ROW_LSB]);
    end
  endfunction
  // ************************************************
  // read data pins pass three flops before sampling
  // ************************************************
  // one chain per byte lane: a lane that is not selected is left floating
  // by the memory and would never agree, so it must not hold back a read
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      anvp_sync3 #(.W(DW / 2)) u_sync (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .d_i(DATA_BUS_I[g * (DW / 2) +: (DW / 2)]),
        .q_o(rd_sync[g * (DW / 2) +: (DW / 2)]),
        .stable_o(lane_stable[g])
      );
    end
  endgenerate
  // deselected lanes count as settled; bit 1 is the upper lane
  // limitation: with both selects high a read completes as soon as cnt runs out, with no data
  assign lane_off = {UPPER_BYTE_SEL_N_O, LOWER_BYTE_SEL_N_O};
  assign rd_stable = &(lane_stable | lane_off);
  // ************************************************
  // access sequencer
  // ************************************************
  // accesses run one at a time; throughput traded for simple timing
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state <= S_PRE;
      cnt <= 8'h00;
      rc_cnt <= 8'h00;
      REQ_READY_O <= 1'b0;
      RSP_VALID_O <= 1'b0;
      RSP_RDATA_O <= {DW{1'b0}};
      WORD_ADDR_O <= {AW{1'b0}};
      CHIP_SEL_N_O <= 1'b1;
      WRITE_STB_N_O <= 1'b1;
      OUT_EN_N_O <= 1'b1;
      UPPER_BYTE_SEL_N_O <= 1'b1;
      LOWER_BYTE_SEL_N_O <= 1'b1;
      DATA_BUS_O <= {DW{1'b0}};
      DATA_BUS_OE_N_O <= 1'b1;
    end else begin
      REQ_READY_O <= 1'b0;
      RSP_VALID_O <= 1'b0;
      if (rc_cnt != 8'h00) begin
        rc_cnt <= rc_cnt - 8'h01;
      end
      if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      case (state)
        // select held high for the pre-charge time after a release; out of reset cnt is zero, so one cycle only
        S_PRE: begin
          CHIP_SEL_N_O <= 1'b1;
          if (cnt == 8'h00) begin
            state <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (REQ_VALID_I) begin
            // select falls with address set; strobe high means read
            WORD_ADDR_O <= REQ_ADDR_I;
            CHIP_SEL_N_O <= 1'b0;
            UPPER_BYTE_SEL_N_O <= ~REQ_BE_I[1];
            LOWER_BYTE_SEL_N_O <= ~REQ_BE_I[0];
            OUT_EN_N_O <= REQ_WRITE_I;
            DATA_BUS_O <= REQ_WDATA_I;
            DATA_BUS_OE_N_O <= ~REQ_WRITE_I;
            REQ_READY_O <= 1'b1;
            rc_cnt <= RC_CYC;
            cnt <= ACC_CYC;
            state <= REQ_WRITE_I ? S_WLOW : S_ACC;
          end
        end
        // read: wait access time (page time within an open row) and three-flop settle
        S_ACC: begin
          // only selected lanes are waited for; the other lane is a don't-care
          if (cnt == 8'h00 && rd_stable) begin
            RSP_VALID_O <= 1'b1;
            RSP_RDATA_O <= rd_sync;
            OUT_EN_N_O <= 1'b1;
            state <= S_OPEN;
          end
        end
        // write strobe low; one pulse per word
        S_WLOW: begin
          WRITE_STB_N_O <= 1'b0;
          if (cnt == 8'h00 && !WRITE_STB_N_O) begin
            WRITE_STB_N_O <= 1'b1;
            cnt <= 8'h01;
            state <= S_WHIGH;
          end
        end
        // keep driving two cycles past the rising strobe for hold
        S_WHIGH: begin
          if (cnt == 8'h00) begin
            DATA_BUS_OE_N_O <= 1'b1;
            state <= S_OPEN;
          end
        end
        // row stays open; next request decides reuse or close
        S_OPEN: begin
          // releasing select starts the device pre-charge; idle after the count
          if (REQ_LAST_I && !REQ_VALID_I) begin
            CHIP_SEL_N_O <= 1'b1;
            UPPER_BYTE_SEL_N_O <= 1'b1;
            LOWER_BYTE_SEL_N_O <= 1'b1;
            cnt <= PC_CYC;
            state <= S_PRE;
          end else if (REQ_VALID_I) begin
            if (same_row(REQ_ADDR_I, WORD_ADDR_O) || rc_cnt == 8'h00) begin
              // column change in row is fast; new row waits for cycle time
              WORD_ADDR_O <= REQ_ADDR_I;
              UPPER_BYTE_SEL_N_O <= ~REQ_BE_I[1];
              LOWER_BYTE_SEL_N_O <= ~REQ_BE_I[0];
              OUT_EN_N_O <= REQ_WRITE_I;
              DATA_BUS_O <= REQ_WDATA_I;
              DATA_BUS_OE_N_O <= ~REQ_WRITE_I;
              REQ_READY_O <= 1'b1;
              if (!same_row(REQ_ADDR_I, WORD_ADDR_O)) begin
                rc_cnt <= RC_CYC;
                cnt <= ACC_CYC;
              end else begin
                cnt <= REQ_WRITE_I ? WP_CYC : PAGE_CYC;
              end
              state <= REQ_WRITE_I ? S_WLOW : S_ACC;
            end
          end
        end
        default: begin
          state <= S_PRE;
        end
      endcase
    end
  end
endmodule // anvp_host
`default_nettype wire

// *** verification/anvp_mem_model.sv ***
// device model of the paged memory port
// assumes the bench resolves the data bus
`timescale 1ns/1ps
`default_nettype none
module anvp_mem_model #(
  parameter int ACC_NS = 60
) (
  input wire logic cs_n,  // select
  input wire logic we_n,  // write strobe
  input wire logic oe_n,  // output enable
  input wire logic ub_n,  // upper lane
  input wire logic lb_n,  // lower lane
  input wire logic [16:0] a,  // word_addr
  input wire logic [15:0] dq,  // bus level
  output logic [15:0] q,  // drive value
  output logic [1:0] drv  // lane drive
);
  logic [15:0] mem [0:131071];
  logic [16:0] wa;
  logic vld = 1'b0;
  int seq = 0;
  // any select edge or address move restarts access
  always @(negedge cs_n or posedge cs_n or a) begin
    vld = 1'b0;
    seq = seq + 1;
    fork
      begin
        automatic int s = seq;
        #ACC_NS;
        if (s == seq && !cs_n) vld = 1'b1;
      end
    join_none
  end
  // no invalid word ever shows
  always_comb begin
    q = mem[a];
    drv = (!cs_n && !oe_n && we_n && vld) ? {~ub_n, ~lb_n} : 2'b00;
  end
  // address at strobe fall, store at first rising end
  always @(negedge we_n) wa = a;
  always @(posedge we_n or posedge cs_n) begin
    if (!cs_n || !we_n) begin
      if (!ub_n) mem[wa][15:8] = dq[15:8];
      if (!lb_n) mem[wa][7:0] = dq[7:0];
    end
  end
endmodule // anvp_mem_model
`default_nettype wire

// *** verification/anvp_host_properties.sv ***
// pin timing checks for the memory port host
// assumes one clock domain and a high reset
`timescale 1ns/1ps
`default_nettype none
module anvp_host_chk #(
  parameter AW = 17,
  parameter DW = 16
) (
  input wire logic CLK_SYS_I,  // clock
  input wire logic RST_I,  // reset
  input wire logic [AW-1:0] REQ_ADDR_I,  // request address
  input wire logic REQ_READY_O,  // taken
  input wire logic RSP_VALID_O,  // read word
  input wire logic [AW-1:0] WORD_ADDR_O,  // address pins
  input wire logic CHIP_SEL_N_O,  // select
  input wire logic WRITE_STB_N_O,  // strobe
  input wire logic OUT_EN_N_O,  // output enable
  input wire logic DATA_BUS_OE_N_O  // host drive
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  property p_rdy; REQ_READY_O |=> !REQ_READY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("ready width");
  property p_adr; REQ_READY_O |-> !CHIP_SEL_N_O && WORD_ADDR_O == $past(REQ_ADDR_I); endproperty
  a_adr: assert property (p_adr) else $error("address pins");
  property p_pc; $rose(CHIP_SEL_N_O) |-> CHIP_SEL_N_O [*6]; endproperty
  a_pc: assert property (p_pc) else $error("precharge short");
  property p_we; !WRITE_STB_N_O |-> !CHIP_SEL_N_O && !DATA_BUS_OE_N_O; endproperty
  a_we: assert property (p_we) else $error("strobe outside");
  property p_wpw; $fell(WRITE_STB_N_O) |=> !WRITE_STB_N_O [*3]; endproperty
  a_wpw: assert property (p_wpw) else $error("strobe width");
  property p_wend; $rose(WRITE_STB_N_O) |-> !DATA_BUS_OE_N_O; endproperty
  a_wend: assert property (p_wend) else $error("data gone at store");
  property p_oe; !OUT_EN_N_O |-> DATA_BUS_OE_N_O && WRITE_STB_N_O; endproperty
  a_oe: assert property (p_oe) else $error("bus fight");
  property p_rw; $fell(OUT_EN_N_O) |-> !RSP_VALID_O [*6]; endproperty
  a_rw: assert property (p_rw) else $error("early sample");
  property p_rd; $fell(OUT_EN_N_O) |-> ##[6:40] RSP_VALID_O; endproperty
  a_rd: assert property (p_rd) else $error("read hang");
endmodule // anvp_host_chk
bind anvp_host anvp_host_chk #(.AW(AW), .DW(DW)) chk (.*);
`default_nettype wire

// *** verification/async_paged_nv_memory_port_test.sv ***
// self-checking bench for the memory port host
// assumes the device model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "anvp_map.vh"
module async_paged_nv_memory_port_test;
  logic clk = 1'b0, rst = 1'b1, vld = 1'b0, wr = 1'b0, lst = 1'b1;
  logic [16:0] ad = '0, wa;
  logic [15:0] wd = '0, rd, hd, q, dq, pq = '0;
  logic [1:0] be = 2'b11, drv;
  logic rdy, rsv, cs_n, we_n, oe_n, ub_n, lb_n, hoe_n;
  int n_mismatch = 0, num_checks = 0, cyc = 0, t_rdy = 0;
  initial forever #5 clk = ~clk;
  // released lanes flip each cycle so stale data never passes
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) pq <= dq;
  assign dq = !hoe_n ? hd : {drv[1] ? q[15:8] : ~pq[15:8], drv[0] ? q[7:0] : ~pq[7:0]};
  anvp_host dut (.CLK_SYS_I(clk), .RST_I(rst), .REQ_VALID_I(vld), .REQ_WRITE_I(wr),
    .REQ_ADDR_I(ad), .REQ_WDATA_I(wd), .REQ_BE_I(be), .REQ_LAST_I(lst),
    .REQ_READY_O(rdy), .RSP_VALID_O(rsv), .RSP_RDATA_O(rd), .WORD_ADDR_O(wa),
    .CHIP_SEL_N_O(cs_n), .WRITE_STB_N_O(we_n), .OUT_EN_N_O(oe_n),
    .UPPER_BYTE_SEL_N_O(ub_n), .LOWER_BYTE_SEL_N_O(lb_n), .DATA_BUS_I(dq),
    .DATA_BUS_O(hd), .DATA_BUS_OE_N_O(hoe_n));
  anvp_mem_model mem (.cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .ub_n(ub_n),
    .lb_n(lb_n), .a(wa), .dq(dq), .q(q), .drv(drv));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait for ready (rsp low) or the read pulse (rsp high), at the falling edge
  task automatic wt(input bit rsp);
    for (int i = 0; i < 200 && (rsp ? rsv : rdy) !== 1'b1; i++) @(negedge clk);
    if ((rsp ? rsv : rdy) !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // one access; with l set select is released after a read only, as the next call clears lst while a write is still strobing
  task automatic acc(input logic w, input logic [16:0] a, input logic [15:0] d,
      input logic [1:0] b, input logic l);
    @(negedge clk);
    vld = 1'b1;
    wr = w;
    ad = a;
    wd = d;
    be = b;
    lst = 1'b0;
    wt(1'b0);
    t_rdy = cyc;
    vld = 1'b0;
    lst = l;
    if (!w) wt(1'b1);
  endtask
  task automatic s_page();
    for (int c = 0; c < 4; c++) begin
      acc(1, 17'h000a4 + 17'(c), 16'ha5a0 + 16'(c), 2'b11, c == 3);
    end
    for (int c = 0; c < 4; c++) begin
      acc(0, 17'h000a4 + 17'(c), 16'h0000, 2'b11, c == 3);
      chk("page word", 16'ha5a0 + c, rd);
    end
  endtask
  task automatic s_rows();
    int t0;
    acc(1, 17'h1fffc, 16'h3c3c, 2'b11, 0);
    acc(1, 17'h00010, 16'hc3c3, 2'b11, 1);
    acc(0, 17'h1fffc, 16'h0000, 2'b11, 0);
    chk("top row", 16'h3c3c, rd);
    t0 = t_rdy;
    acc(0, 17'h00010, 16'h0000, 2'b11, 1);
    chk("low row", 16'hc3c3, rd);
    chk("row gap", 1, t_rdy - t0 >= `ANVP_RC_CYC);
  endtask
  task automatic s_bytes();
    acc(1, 17'h05555, 16'hffff, 2'b11, 0);
    acc(1, 17'h05555, 16'h1234, 2'b01, 0);
    acc(1, 17'h05556, 16'h0000, 2'b11, 0);
    acc(1, 17'h05556, 16'h5678, 2'b10, 0);
    acc(0, 17'h05555, 16'h0000, 2'b11, 0);
    chk("lower lane", 16'hff34, rd);
    acc(0, 17'h05556, 16'h0000, 2'b11, 0);
    chk("upper lane", 16'h5600, rd);
    // single-lane reads: the other lane floats and must not stall the read
    acc(0, 17'h05555, 16'h0000, 2'b01, 0);
    chk("lower only", 16'h0034, {8'h00, rd[7:0]});
    acc(0, 17'h05556, 16'h0000, 2'b10, 1);
    chk("upper only", 16'h5600, {rd[15:8], 8'h00});
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    s_page();
    s_rows();
    s_bytes();
    repeat (20) @(negedge clk);
    final_report();
  end
endmodule // async_paged_nv_memory_port_test
`default_nettype wire
